// ==== hw/ptimer.sv ====
// Periodic timer core with AXI4-Lite register slave
`timescale 1ns/1ps
`include "ptimer_defines.svh"
// Summary of operation
// - Read-only counter pair plus compare A and period pairs, 10 or 16 bits.
// - Only instance zero has compare B pair and third control register.
// - Ten-bit instances keep only bits 9 and 8 in high bytes.
// - Pause bit set stops counting; cleared resumes counting.
// - Paused counter holds value and resumes from it.
// - Three-bit clock select picks sys/4, sys, high/16, high/64, sub, pin edges.
// - Run bit rising clears counter to zero and starts counting.
// - Run bit falling stops counter, keeping its present value.
// - Run rising sets output pin to initial level, or to its inverse in PWM mode.
// - Mode field: compare output, capture, PWM/single pulse, timer/counter.
// - Output pin level undefined in timer/counter mode.
// - Control zero bits 2 to 0 always read zero.
// - Low bytes go via buffer; high write commits, high read latches low.
// - Counter clears on overflow or selected compare match, raising interrupt.
// - In PWM mode pin function picks inactive, active, PWM, single pulse.
module ptimer #(
  parameter int WIDTH    = 16,
  parameter bit HAS_CMPB = 1'b1
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        CLK_EN,
  input  wire logic        HIGH_CLK_TICK,
  input  wire logic        SUB_CLK_TICK,
  input  wire logic        EXT_COUNT_CLK,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             TIMER_OUT,
  output logic             TIMER_OUT_N,
  output logic             IRQ
);
  // --------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------
  logic [7:0]          ctrl0_q;
  ptimer_pkg::ctrl1_s  ctrl1_q;
  logic [2:0]          ctrl2_q;
  logic [WIDTH-1:0]    count_q;
  logic [WIDTH-1:0]    cmpa_q;
  logic [WIDTH-1:0]    cmpb_q;
  logic [WIDTH-1:0]    per_q;
  logic [7:0]          wbuf_q;
  logic [7:0]          rbuf_q;
  ptimer_pkg::irq_t    stat_q;
  ptimer_pkg::irq_t    mask_q;
  logic                run_q;
  logic                pin_q;
  logic [7:0]          pre_q;
  logic                ext_s1_q;
  logic                ext_s2_q;
  logic                ext_s3_q;
  logic                pulse_done_q;
  // AXI write path holding registers
  logic                aw_have_q;
  logic                w_have_q;
  logic [7:0]          aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  // --------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------
  logic                pause;
  logic                run_bit;
  ptimer_pkg::cksel_e  cksel;
  logic                run_rise;
  logic                tick;
  logic                ext_rise;
  logic                ext_fall;
  logic                match_a;
  logic                match_p;
  logic                ovf;
  logic                clr_cnt;
  logic                do_write;
  logic                do_read;
  logic                wr_lane0;
  ptimer_pkg::irq_t    events;
  assign pause    = ctrl0_q[`B_PAUSE];
  assign run_bit  = ctrl0_q[`B_RUN];
  assign cksel    = ptimer_pkg::cksel_e'(ctrl0_q[`B_CKSEL_HI:`B_CKSEL_LO]);
  assign run_rise = run_bit & ~run_q;
  assign ext_rise = ext_s2_q & ~ext_s3_q;
  assign ext_fall = ~ext_s2_q & ext_s3_q;
  // --------------------------------------------------------------------
  // Clock source selection
  // --------------------------------------------------------------------
  // Prescaler runs freely; tick is a one-cycle count enable
  always_comb begin
    case (cksel)
      ptimer_pkg::CK_SYS4: tick = (pre_q[1:0] == 2'(`DIV_SYS4));
      ptimer_pkg::CK_SYS:  tick = 1'b1;
      ptimer_pkg::CK_H16:  tick = HIGH_CLK_TICK & (pre_q[3:0] == 4'(`DIV_H16));
      ptimer_pkg::CK_H64:  tick = HIGH_CLK_TICK & (pre_q[5:0] == 6'(`DIV_H64));
      ptimer_pkg::CK_SUB0,
      ptimer_pkg::CK_SUB1: tick = SUB_CLK_TICK;
      ptimer_pkg::CK_EXTR: tick = ext_rise;
      ptimer_pkg::CK_EXTF: tick = ext_fall;
      default:             tick = 1'b0;
    endcase
  end

  // Sys/4 counts on every clock, high-clock dividers on its ticks
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pre_q <= 8'h00;
    end else if (CLK_EN) begin
      if (cksel == ptimer_pkg::CK_SYS4 || HIGH_CLK_TICK) begin
        pre_q <= pre_q + 8'h01;
      end
    end
  end

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (CLK_EN) begin
      ext_s1_q <= EXT_COUNT_CLK;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  assign match_a = tick & (count_q == cmpa_q);
  assign match_p = tick & (count_q == per_q) & (per_q != '0);
  assign ovf     = tick & (&count_q) & (per_q == '0);
  // Clear source: comparator A, or P / overflow; capture and PWM use P
  assign clr_cnt = (ctrl1_q.counter_clear_select &&
                    ctrl1_q.mode inside {ptimer_pkg::MODE_CMP,
                                         ptimer_pkg::MODE_TMR})
                   ? match_a : (match_p | ovf);
  assign events  = {match_p | ovf, match_a};

  // Run edge wins over counting; pause and off freeze the value
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      count_q <= '0;
      run_q   <= 1'b0;
    end else if (CLK_EN) begin
      run_q <= run_bit;
      if (run_rise) begin
        count_q <= '0;
      end else if (run_bit && !pause && tick) begin
        count_q <= clr_cnt ? '0 : count_q + 1'b1;
      end
    end
  end
  // --------------------------------------------------------------------
  // Output pin
  // --------------------------------------------------------------------
  // Polarity applied at the pin; timer mode leaves it at last value
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pin_q        <= 1'b0;
      pulse_done_q <= 1'b0;
    end else if (CLK_EN) begin
      if (run_rise) begin
        pin_q        <= ctrl1_q.mode == ptimer_pkg::MODE_PWM
                        ? ~ctrl1_q.output_initial_level
                        : ctrl1_q.output_initial_level;
        pulse_done_q <= 1'b0;
      end else if (run_bit && !pause) begin
        case (ctrl1_q.mode)
          ptimer_pkg::MODE_CMP: begin
            if (match_a) begin
              case (ctrl1_q.pin_function_select)
                2'b01:   pin_q <= 1'b0;
                2'b10:   pin_q <= 1'b1;
                2'b11:   pin_q <= ~pin_q;
                default: pin_q <= pin_q;
              endcase
            end
          end
          ptimer_pkg::MODE_PWM: begin
            case (ctrl1_q.pin_function_select)
              2'b00: pin_q <= ~ctrl1_q.output_initial_level;
              2'b01: pin_q <= ctrl1_q.output_initial_level;
              2'b10: begin
                if (match_p | ovf) begin
                  pin_q <= ctrl1_q.output_initial_level;
                end else if (match_a) begin
                  pin_q <= ~ctrl1_q.output_initial_level;
                end
              end
              default: begin
                // Single pulse: active from start until compare A
                if (!pulse_done_q) begin
                  pin_q <= ctrl1_q.output_initial_level;
                  if (match_a) begin
                    pin_q        <= ~ctrl1_q.output_initial_level;
                    pulse_done_q <= 1'b1;
                  end
                end
              end
            endcase
          end
          default: pin_q <= pin_q;
        endcase
      end
    end
  end

  // Registered pin drivers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      TIMER_OUT   <= 1'b0;
      TIMER_OUT_N <= 1'b1;
    end else if (CLK_EN) begin
      TIMER_OUT   <= pin_q ^ ctrl1_q.output_polarity;
      TIMER_OUT_N <= ~(pin_q ^ ctrl1_q.output_polarity);
    end
  end
  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  assign do_write = aw_have_q & w_have_q & ~S_AXI_BVALID;
  assign wr_lane0 = w_strb_q[0];

  // Address and data taken in either order, response after both
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
    end else if (CLK_EN) begin
      S_AXI_AWREADY <= ~aw_have_q & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY  <= ~w_have_q & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= 2'b00;
        case (aw_addr_q)
          `OFS_CTRL0, `OFS_CTRL1, `OFS_CNT_LO, `OFS_CNT_HI,
          `OFS_CMPA_LO, `OFS_CMPA_HI, `OFS_PER_LO, `OFS_PER_HI,
          `OFS_IRQ_STAT, `OFS_IRQ_MASK: S_AXI_BRESP <= 2'b00;
          `OFS_CTRL2, `OFS_CMPB_LO, `OFS_CMPB_HI:
            S_AXI_BRESP <= HAS_CMPB ? 2'b00 : 2'b10;
          default: S_AXI_BRESP <= 2'b10;
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Control and compare storage; high byte commits the buffered low
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl0_q <= `RST_CTRL0;
      ctrl1_q <= ptimer_pkg::ctrl1_s'(`RST_CTRL1);
      ctrl2_q <= 3'(`RST_CTRL2);
      cmpa_q  <= '0;
      cmpb_q  <= '0;
      per_q   <= '0;
      wbuf_q  <= 8'h00;
      mask_q  <= 2'b00;
    end else if (CLK_EN && do_write && wr_lane0) begin
      case (aw_addr_q)
        `OFS_CTRL0: ctrl0_q <= {w_data_q[7:3], 3'b000};
        `OFS_CTRL1: ctrl1_q <= ptimer_pkg::ctrl1_s'(w_data_q[7:0]);
        `OFS_CTRL2: if (HAS_CMPB) ctrl2_q <= {w_data_q[2:1], 1'b0};
        `OFS_CMPA_LO, `OFS_PER_LO, `OFS_CMPB_LO:
          wbuf_q <= w_data_q[7:0];
        `OFS_CMPA_HI:
          cmpa_q <= WIDTH'({w_data_q[7:0], wbuf_q});
        `OFS_PER_HI:
          per_q  <= WIDTH'({w_data_q[7:0], wbuf_q});
        `OFS_CMPB_HI:
          if (HAS_CMPB) cmpb_q <= WIDTH'({w_data_q[7:0], wbuf_q});
        `OFS_IRQ_MASK: mask_q <= w_data_q[1:0];
        default: ;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // AXI4-Lite read channel and interrupt status
  // --------------------------------------------------------------------
  assign do_read = S_AXI_ARVALID & S_AXI_ARREADY;
  logic [15:0] cnt16;
  logic [15:0] cmpa16;
  logic [15:0] cmpb16;
  logic [15:0] per16;
  assign cnt16  = 16'(count_q);
  assign cmpa16 = 16'(cmpa_q);
  assign cmpb16 = 16'(cmpb_q);
  assign per16  = 16'(per_q);

  // Ready only while idle so a single read is outstanding
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= 2'b00;
      rbuf_q        <= 8'h00;
    end else if (CLK_EN) begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (do_read) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= 2'b00;
        S_AXI_RDATA  <= 32'h0000_0000;
        case (S_AXI_ARADDR)
          `OFS_CTRL0:  S_AXI_RDATA[7:0] <= ctrl0_q;
          `OFS_CTRL1:  S_AXI_RDATA[7:0] <= ctrl1_q;
          `OFS_CTRL2:  begin
            if (HAS_CMPB) S_AXI_RDATA[2:0] <= ctrl2_q;
            else S_AXI_RRESP <= 2'b10;
          end
          `OFS_CNT_HI:  begin
            S_AXI_RDATA[7:0] <= cnt16[15:8];
            rbuf_q           <= cnt16[7:0];
          end
          `OFS_CMPA_HI: begin
            S_AXI_RDATA[7:0] <= cmpa16[15:8];
            rbuf_q           <= cmpa16[7:0];
          end
          `OFS_PER_HI:  begin
            S_AXI_RDATA[7:0] <= per16[15:8];
            rbuf_q           <= per16[7:0];
          end
          `OFS_CMPB_HI: begin
            if (HAS_CMPB) begin
              S_AXI_RDATA[7:0] <= cmpb16[15:8];
              rbuf_q           <= cmpb16[7:0];
            end else S_AXI_RRESP <= 2'b10;
          end
          `OFS_CNT_LO, `OFS_CMPA_LO, `OFS_PER_LO:
            S_AXI_RDATA[7:0] <= rbuf_q;
          `OFS_CMPB_LO: begin
            if (HAS_CMPB) S_AXI_RDATA[7:0] <= rbuf_q;
            else S_AXI_RRESP <= 2'b10;
          end
          `OFS_IRQ_STAT: S_AXI_RDATA[1:0] <= stat_q;
          `OFS_IRQ_MASK: S_AXI_RDATA[1:0] <= mask_q;
          default:       S_AXI_RRESP <= 2'b10;
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Sticky events; read clears, but a same-cycle event survives
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      stat_q <= 2'b00;
      IRQ    <= 1'b0;
    end else if (CLK_EN) begin
      if (do_read && S_AXI_ARADDR == `OFS_IRQ_STAT) begin
        stat_q <= events & {2{run_bit & ~pause}};
      end else begin
        stat_q <= stat_q | (events & {2{run_bit & ~pause}});
      end
      IRQ <= |(stat_q & mask_q);
    end
  end
endmodule // ptimer

// ==== hw/ptimer_defines.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PTIMER_DEFINES_SVH
`define PTIMER_DEFINES_SVH
// ----------------------------------------------------------------------
// Register byte addresses (one aligned word each)
// ----------------------------------------------------------------------
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_CTRL2      8'h08
`define OFS_CNT_LO     8'h0C
`define OFS_CNT_HI     8'h10
`define OFS_CMPA_LO    8'h14
`define OFS_CMPA_HI    8'h18
`define OFS_CMPB_LO    8'h1C
`define OFS_CMPB_HI    8'h20
`define OFS_PER_LO     8'h24
`define OFS_PER_HI     8'h28
`define OFS_IRQ_STAT   8'h2C
`define OFS_IRQ_MASK   8'h30
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define B_PAUSE        7
`define B_CKSEL_HI     6
`define B_CKSEL_LO     4
`define B_RUN          3
`define B_MODE_HI      7
`define B_MODE_LO      6
`define B_PINF_HI      5
`define B_PINF_LO      4
`define B_INIT_LVL     3
`define B_POL          2
`define B_CLR_SEL      0
// ----------------------------------------------------------------------
// Reset values and divider counts
// ----------------------------------------------------------------------
`define RST_CTRL0      8'h00
`define RST_CTRL1      8'h00
`define RST_CTRL2      8'h00
`define DIV_SYS4       8'h03
`define DIV_H16        8'h0F
`define DIV_H64        8'h3F
`endif

// ==== hw/ptimer_pkg.sv ====
// Types shared by the periodic timer design
package ptimer_pkg;
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } mode_e;
  typedef enum logic [2:0] {
    CK_SYS4  = 3'b000,
    CK_SYS   = 3'b001,
    CK_H16   = 3'b010,
    CK_H64   = 3'b011,
    CK_SUB0  = 3'b100,
    CK_SUB1  = 3'b101,
    CK_EXTR  = 3'b110,
    CK_EXTF  = 3'b111
  } cksel_e;
  typedef enum logic [2:0] {
    AX_IDLE = 3'b001,
    AX_RESP = 3'b010,
    AX_HOLD = 3'b100
  } axst_e;
  // Control register one fields
  typedef struct packed {
    mode_e      mode;
    logic [1:0] pin_function_select;
    logic       output_initial_level;
    logic       output_polarity;
    logic       capture_source_select;
    logic       counter_clear_select;
  } ctrl1_s;
  // Interrupt event bits: [0] compare A, [1] compare P / overflow
  typedef logic [1:0] irq_t;
endpackage

// ==== verification/ptimer_checker.sv ====
// Port-level assertions for the periodic timer
`timescale 1ns/1ps
module ptimer_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        TIMER_OUT,
  input wire logic        TIMER_OUT_N,
  input wire logic        IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Both halves of a write taken on one edge
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_taken |-> ##[1:2] S_AXI_RVALID)
    else $error("read data missing");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while data pending");
  a_aw_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("address ready held");
  a_bresp_legal: assert property (S_AXI_BVALID
    |-> S_AXI_BRESP inside {2'b00, 2'b10})
    else $error("illegal write response");
  a_pin_inverse: assert property (TIMER_OUT_N == !TIMER_OUT)
    else $error("inverted pin mismatch");
  // Registered outputs must come out of reset quiet
  a_reset_quiet: assert property ($rose(RST_N) |-> !IRQ && !TIMER_OUT
    && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("outputs active after reset");
endmodule // ptimer_checker

bind ptimer ptimer_checker u_ptimer_checker (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .TIMER_OUT(TIMER_OUT),
  .TIMER_OUT_N(TIMER_OUT_N), .IRQ(IRQ));

// ==== verification/tb.sv ====
// Self-checking bench for the periodic timer
`timescale 1ns/1ps
module tb;
  logic        clk, rst_n, ht, st, ext, tout, tout_n, irq, clk_en;
  logic [3:0]  strb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [1:0]  bresp, rresp;
  int          err_total, checks, cyc;

  ptimer u_ptimer (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en),
    .HIGH_CLK_TICK(ht), .SUB_CLK_TICK(st), .EXT_COUNT_CLK(ext),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .TIMER_OUT(tout),
    .TIMER_OUT_N(tout_n), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Tick sources: high clock every 2nd, sub every 4th, pin period 16
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ht <= cyc[0];
    st <= (cyc[1:0] == 2'b00);
    ext <= cyc[3];
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic rng(input logic [31:0] g, input int lo, input int hi);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = 2'b00);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk(bresp, e);
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] e = 2'b00);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    d = rdata;
    chk(rresp, e);
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // High byte first so the low byte comes from the latched buffer
  task automatic cnt(output logic [15:0] v);
    logic [31:0] h, l;
    rd(8'h10, h);
    rd(8'h0C, l);
    v = {h[7:0], l[7:0]};
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rc(8'h00, 32'h0000_0000);
    rc(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_00F7);
    rc(8'h00, 32'h0000_00F0);
    wr(8'h00, 32'h0000_0000);
    // Lane zero strobe low: accepted, nothing stored
    strb <= 4'h0;
    wr(8'h00, 32'h0000_0008);
    strb <= 4'hF;
    rc(8'h00, 32'h0000_0000);
    wr(8'h10, 32'h0000_00AA);
    rc(8'h10, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(8'h14 + 8'(8 * i), 32'h0000_005A + i);
      wr(8'h18 + 8'(8 * i), 32'h0000_00C3);
      rc(8'h18 + 8'(8 * i), 32'h0000_00C3);
      rc(8'h14 + 8'(8 * i), 32'h0000_005A + i);
    end
    rd(8'h3C, d, 2'b10);
    chk(d, 32'h0000_0000);
    wr(8'h3C, 32'h0000_00FF, 2'b10);
    $display("test regs done");
  endtask

  // Every clock source should give about 100 counts over its window
  task automatic t_clk();
    int w[8] = '{400, 100, 3200, 12800, 400, 400, 1600, 1600};
    logic [15:0] v;
    wr(8'h04, 32'h0000_00C0);
    for (int s = 0; s < 8; s++) begin
      wr(8'h00, 32'h0000_0000);
      wr(8'h00, {24'h0, 1'b0, 3'(s), 4'h8});
      repeat (w[s]) @(posedge clk);
      cnt(v);
      rng(v, 98, 108);
    end
    $display("test clock select done");
  endtask

  task automatic t_pause();
    logic [15:0] a, b;
    wr(8'h00, 32'h0000_0018);
    repeat (100) @(posedge clk);
    wr(8'h00, 32'h0000_0098);
    cnt(a);
    repeat (40) @(posedge clk);
    cnt(b);
    chk(b, a);
    wr(8'h00, 32'h0000_0018);
    repeat (40) @(posedge clk);
    cnt(b);
    rng(b, a + 40, a + 60);
    // Clock enable low must freeze the running counter
    cnt(a);
    clk_en <= 1'b0;
    repeat (30) @(posedge clk);
    clk_en <= 1'b1;
    cnt(b);
    rng(b, a + 6, a + 10);
    wr(8'h00, 32'h0000_0010);
    cnt(a);
    repeat (40) @(posedge clk);
    cnt(b);
    chk(b, a);
    wr(8'h00, 32'h0000_0018);
    cnt(b);
    rng(b, 0, 12);
    $display("test pause done");
  endtask

  task automatic t_irq();
    logic [15:0] v;
    wr(8'h00, 32'h0000_0000);
    wr(8'h14, 32'h0000_0010);
    wr(8'h18, 32'h0000_0000);
    wr(8'h04, 32'h0000_00C1);
    wr(8'h30, 32'h0000_0001);
    rc(8'h2C, 32'h0000_0000);
    wr(8'h00, 32'h0000_0018);
    repeat (40) @(posedge clk);
    chk(irq, 1'b1);
    cnt(v);
    rng(v, 0, 16);
    wr(8'h00, 32'h0000_0000);
    rc(8'h2C, 32'h0000_0001);
    rc(8'h2C, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    wr(8'h30, 32'h0000_0000);
    wr(8'h00, 32'h0000_0018);
    repeat (40) @(posedge clk);
    chk(irq, 1'b0);
    wr(8'h00, 32'h0000_0000);
    rc(8'h2C, 32'h0000_0001);
    $display("test interrupt done");
  endtask

  // Compare output driving high on match, back to initial level on run
  task automatic t_pin();
    wr(8'h04, 32'h0000_0020);
    wr(8'h00, 32'h0000_0018);
    chk(tout, 1'b0);
    repeat (40) @(posedge clk);
    chk({tout, tout_n}, 2'b10);
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0018);
    repeat (2) @(posedge clk);
    chk(tout, 1'b0);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0008);
    wr(8'h00, 32'h0000_0018);
    repeat (40) @(posedge clk);
    chk(tout, 1'b1);
    // PWM forced levels, then the polarity bit at the pin
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0088);
    wr(8'h00, 32'h0000_0018);
    repeat (4) @(posedge clk);
    chk(tout, 1'b0);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0098);
    wr(8'h00, 32'h0000_0018);
    repeat (4) @(posedge clk);
    chk(tout, 1'b1);
    wr(8'h04, 32'h0000_009C);
    repeat (2) @(posedge clk);
    chk({tout, tout_n}, 2'b01);
    $display("test pin done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {rst_n, ht, st, ext, awv, wv, br, arv, rr} = '0;
    {awaddr, araddr, wdata} = '0;
    {err_total, checks, cyc} = '0;
    {clk_en, strb} = 5'h1F;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_clk();
    t_pause();
    t_irq();
    t_pin();
    summarize();
  end
endmodule // tb
